// ==== core/tvs_pkg.sv ====
package tvs_pkg;

  // ----------------------------------------------------------------
  // Register map (word offsets on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MODE      = 8'h00;
  localparam logic [7:0] OFS_TSRC      = 8'h01;
  localparam logic [7:0] OFS_TDIG      = 8'h02;
  localparam logic [7:0] OFS_FWD_LIM   = 8'h03;
  localparam logic [7:0] OFS_REV_LIM   = 8'h04;
  localparam logic [7:0] OFS_ACC       = 8'h05;
  localparam logic [7:0] OFS_DEC       = 8'h06;
  localparam logic [7:0] OFS_VDI_FN0   = 8'h08;
  localparam logic [7:0] OFS_VDI_MODE  = 8'h0D;
  localparam logic [7:0] OFS_VDI_FORCE = 8'h0E;
  localparam logic [7:0] OFS_COMM_TRQ  = 8'h10;
  localparam logic [7:0] OFS_STATUS    = 8'h11;
  localparam logic [7:0] OFS_TARGET    = 8'h12;
  localparam logic [7:0] OFS_FAULT_CLR = 8'h13;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam int          NUM_VDI        = 5;
  localparam logic        RST_MODE       = 1'b0;
  localparam logic [2:0]  RST_TSRC       = 3'h0;
  // Torque in 0.1 % units; 1500 = 150.0 %
  localparam logic [15:0] RST_TDIG       = 16'h05DC;
  localparam logic [15:0] TDIG_MAX       = 16'h07D0;
  // Frequency in 0.01 Hz units; 5000 = 50.00 Hz
  localparam logic [15:0] RST_FREQ_LIM   = 16'h1388;
  // Time in 0.01 s units, 0 = no ramp
  localparam logic [15:0] RST_RAMP       = 16'h0000;
  localparam logic [5:0]  RST_VDI_FN     = 6'h00;
  localparam logic [5:0]  VDI_FN_MAX     = 6'h3B;
  localparam logic [4:0]  RST_VDI_BITS   = 5'h00;
  localparam logic [5:0]  FN_TRQ_INHIBIT = 6'h1D;
  localparam logic [5:0]  FN_MODE_SWAP   = 6'h2E;
  localparam logic [5:0]  FN_USER_FAULT1 = 6'h2C;
  localparam logic [7:0]  USER_FAULT_ONE_CODE = 8'h1B;
  // Full scale of 100.00 % on the host comm word and analog inputs
  localparam logic [15:0] FULL_SCALE     = 16'h2710;
  // Ramp step grain: cycles per 0.01 s at 200 MHz
  localparam real         CLK_MHZ        = 200.0;
  localparam int          TICK_CYC       = int'(CLK_MHZ * 10000.0);

  typedef enum logic [2:0] {
    TSRC_DIGITAL = 3'd0,
    TSRC_AI1     = 3'd1,
    TSRC_AI2     = 3'd2,
    TSRC_AI3     = 3'd3,
    TSRC_PULSE   = 3'd4,
    TSRC_COMM    = 3'd5,
    TSRC_MIN12   = 3'd6,
    TSRC_MAX12   = 3'd7
  } tvs_src_e;

  typedef enum logic [1:0] {
    COMM_HOST  = 2'd0,
    COMM_FBUS  = 2'd1,
    COMM_P2P   = 2'd2
  } tvs_comm_e;

  typedef struct packed {
    logic [15:0] ai1;
    logic [15:0] ai2;
    logic [15:0] ai3;
    logic [15:0] pulse;
    logic [15:0] fbus_word;
    logic [15:0] p2p_word;
  } tvs_src_s;

  typedef struct packed {
    logic        torque_mode;
    logic        forward;
    logic        reverse;
    logic        user_fault;
    logic [7:0]  fault_code;
  } tvs_stat_s;

endpackage : tvs_pkg

// ==== core/tvs_top.sv ====
// Functional notes
// [RL1] Mode parameter 0 speed, 1 torque
// [RL2] Swap-input active inverts the mode parameter
// [RL3] Inhibit input forces speed control
// [RL4] Source select picks eight torque sources
// [RL5] Digital setpoint signed, +-200.0%, default 150.0%
// [RL6] Positive torque forward, negative reverse
// [RL7] Digital source used directly, unscaled
// [RL8] Analog full scale maps to digital setpoint
// [RL9] Pulse only from fast input, scaled
// [RL10] Host comm word scaled to digital setpoint
// [RL11] Fieldbus word used directly as torque
// [RL12] Point-to-point slave uses master value
// [RL13] Only one communication protocol active
// [RL14] Forward and reverse frequency limits
// [RL15] Accel/decel ramp, zero means none
// [RL16] Five virtual input function codes 0-59
// [RL17] Per-input source bit and forced state
// [RL18] Virtual input follows same-number output
// [RL19] User fault function raises fault, stops
// [RL20] Output code 0 mirrors physical input
// [RL21] Everything re-evaluated every cycle
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module tvs_top
  import tvs_pkg::*;
#(
  parameter int TICK = TICK_CYC
)(
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  // Register port
  input  wire logic [7:0]       addr_in,
  input  wire logic [15:0]      wdata_in,
  input  wire logic             wr_in,
  input  wire logic             rd_in,
  output logic      [15:0]      rdata_out,
  // Terminals and sources
  input  wire logic             di_swap_in,
  input  wire logic             di_inhibit_in,
  input  wire logic [4:0]       phys_di_in,
  input  wire logic [4:0]       vdo_state_in,
  input  wire logic [4:0]       vdo_fn_zero_in,
  input  wire logic [1:0]       comm_sel_in,
  input  wire logic             fbus_trq_in,
  input  wire tvs_src_s         src_in,
  // Results
  output logic                  torque_mode_out,
  output logic      [15:0]      target_torque_out,
  output logic      [15:0]      freq_limit_out,
  output logic      [4:0]       vdi_state_out,
  output logic                  run_fwd_out,
  output logic                  run_rev_out,
  output logic                  stop_out,
  output logic      [7:0]       fault_code_out
);

  // ----------------------------------------------------------------
  // Parameter registers
  // ----------------------------------------------------------------
  logic        mode_reg;
  logic [2:0]  tsrc_reg;
  logic [15:0] tdig_reg;
  logic [15:0] fwd_lim_reg;
  logic [15:0] rev_lim_reg;
  logic [15:0] acc_reg;
  logic [15:0] dec_reg;
  logic [5:0]  vdi_fn_reg [NUM_VDI];
  logic [4:0]  vdi_mode_reg;
  logic [4:0]  vdi_force_reg;
  logic [15:0] comm_reg;
  logic        fault_reg;
  logic [15:0] ramp_reg;
  logic [15:0] rdata_reg;
  logic [31:0] tick_reg;
  logic [15:0] rd_mux;

  wire w_mode  = wr_in && addr_in == OFS_MODE;
  wire w_tsrc  = wr_in && addr_in == OFS_TSRC;
  wire w_tdig  = wr_in && addr_in == OFS_TDIG;
  wire w_fwd   = wr_in && addr_in == OFS_FWD_LIM;
  wire w_rev   = wr_in && addr_in == OFS_REV_LIM;
  wire w_acc   = wr_in && addr_in == OFS_ACC;
  wire w_dec   = wr_in && addr_in == OFS_DEC;
  wire w_vmode = wr_in && addr_in == OFS_VDI_MODE;
  wire w_vforc = wr_in && addr_in == OFS_VDI_FORCE;
  wire w_comm  = wr_in && addr_in == OFS_COMM_TRQ;
  wire w_fclr  = wr_in && addr_in == OFS_FAULT_CLR && wdata_in[0];

  // Out-of-range setpoint writes are refused, value kept
  wire signed [15:0] wsig   = signed'(wdata_in);
  wire               tdig_ok = wsig <= signed'(TDIG_MAX)
                               && wsig >= -signed'(TDIG_MAX); // RL5

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      mode_reg      <= RST_MODE;
      tsrc_reg      <= RST_TSRC;
      tdig_reg      <= RST_TDIG;
      fwd_lim_reg   <= RST_FREQ_LIM;
      rev_lim_reg   <= RST_FREQ_LIM;
      acc_reg       <= RST_RAMP;
      dec_reg       <= RST_RAMP;
      vdi_mode_reg  <= RST_VDI_BITS;
      vdi_force_reg <= RST_VDI_BITS;
      comm_reg      <= 16'h0000;
    end
    else
    begin
      if (w_mode)  mode_reg <= wdata_in[0]; // RL1
      if (w_tsrc)  tsrc_reg <= wdata_in[2:0]; // RL4
      if (w_tdig && tdig_ok) tdig_reg <= wdata_in; // RL5
      if (w_fwd)   fwd_lim_reg <= wdata_in; // RL14
      if (w_rev)   rev_lim_reg <= wdata_in; // RL14
      if (w_acc)   acc_reg <= wdata_in; // RL15
      if (w_dec)   dec_reg <= wdata_in; // RL15
      if (w_vmode) vdi_mode_reg <= wdata_in[4:0]; // RL17
      if (w_vforc) vdi_force_reg <= wdata_in[4:0]; // RL17
      if (w_comm)  comm_reg <= wdata_in; // RL10
    end
  end

  // ----------------------------------------------------------------
  // Virtual digital inputs
  // ----------------------------------------------------------------
  logic [4:0] vdo_eff;
  logic [4:0] vdi_state;
  logic [4:0] vdi_swap;
  logic [4:0] vdi_inh;
  logic [4:0] vdi_flt;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_VDI; gi++)
    begin : g_vdi
      wire w_fn = wr_in && addr_in == OFS_VDI_FN0 + 8'(gi);
      always_ff @(posedge clk_in or negedge nrst_in)
      begin
        if (!nrst_in)
          vdi_fn_reg[gi] <= RST_VDI_FN;
        else if (w_fn && wdata_in[5:0] <= VDI_FN_MAX)
          vdi_fn_reg[gi] <= wdata_in[5:0]; // RL16
      end
      // Code 0 on an output shorts it to its physical input
      assign vdo_eff[gi]   = vdo_fn_zero_in[gi] ? phys_di_in[gi]
                                                : vdo_state_in[gi]; // RL20
      assign vdi_state[gi] = vdi_mode_reg[gi] ? vdi_force_reg[gi]
                                              : vdo_eff[gi]; // RL17 RL18
      assign vdi_swap[gi]  = vdi_state[gi]
                             && vdi_fn_reg[gi] == FN_MODE_SWAP; // RL16
      assign vdi_inh[gi]   = vdi_state[gi]
                             && vdi_fn_reg[gi] == FN_TRQ_INHIBIT; // RL16
      assign vdi_flt[gi]   = vdi_state[gi]
                             && vdi_fn_reg[gi] == FN_USER_FAULT1; // RL19
    end
  endgenerate

  // ----------------------------------------------------------------
  // Control mode
  // ----------------------------------------------------------------
  wire swap_act = di_swap_in || (|vdi_swap);
  wire inh_act  = di_inhibit_in || (|vdi_inh);
  // Inhibit beats both the parameter and the swap input
  wire torque_mode = !inh_act && (mode_reg ^ swap_act); // RL1 RL2 RL3 RL21

  // ----------------------------------------------------------------
  // Torque source and scaling
  // ----------------------------------------------------------------
  // Scale a +-100.00 % word so full scale gives the digital setpoint
  function automatic logic signed [15:0] scale_fs(
    input logic [15:0] v
  );
    logic signed [31:0] p;
    p = signed'(v) * signed'(tdig_reg);
    return 16'(p / signed'({16'h0000, FULL_SCALE}));
  endfunction : scale_fs

  wire signed [15:0] ai1_s = signed'(src_in.ai1);
  wire signed [15:0] ai2_s = signed'(src_in.ai2);
  wire [15:0] ai_min = (ai1_s < ai2_s) ? src_in.ai1 : src_in.ai2;
  wire [15:0] ai_max = (ai1_s < ai2_s) ? src_in.ai2 : src_in.ai1;

  // One protocol owns the comm word at a time
  logic [15:0] comm_word;
  always_comb
  begin
    unique case (tvs_comm_e'(comm_sel_in)) // RL13
      COMM_FBUS: comm_word = fbus_trq_in ? src_in.fbus_word // RL11
                                         : scale_fs(comm_reg);
      COMM_P2P:  comm_word = src_in.p2p_word; // RL12
      default:   comm_word = scale_fs(comm_reg); // RL10
    endcase
  end

  logic [15:0] tgt;
  always_comb
  begin
    unique case (tvs_src_e'(tsrc_reg)) // RL4
      TSRC_DIGITAL: tgt = tdig_reg; // RL7
      TSRC_AI1:     tgt = scale_fs(src_in.ai1); // RL8
      TSRC_AI2:     tgt = scale_fs(src_in.ai2); // RL8
      TSRC_AI3:     tgt = scale_fs(src_in.ai3); // RL8
      TSRC_PULSE:   tgt = scale_fs(src_in.pulse); // RL9
      TSRC_COMM:    tgt = comm_word;
      TSRC_MIN12:   tgt = scale_fs(ai_min);
      TSRC_MAX12:   tgt = scale_fs(ai_max);
    endcase
  end

  // ----------------------------------------------------------------
  // Ramp and limits
  // ----------------------------------------------------------------
  wire signed [15:0] tgt_s  = signed'(tgt);
  wire signed [15:0] ramp_s = signed'(ramp_reg);
  wire rising   = tgt_s > ramp_s;
  wire [15:0] step_time = rising ? acc_reg : dec_reg;
  // Zero time jumps straight to target for fastest response
  wire no_ramp  = step_time == RST_RAMP; // RL15
  wire tick_hit = tick_reg >= 32'(TICK) - 32'd1;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ramp_reg <= 16'h0000;
      tick_reg <= 32'h0000_0000;
      fault_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end
    else
    begin
      tick_reg <= tick_hit ? 32'h0000_0000 : tick_reg + 32'd1;
      if (no_ramp)
        ramp_reg <= tgt; // RL15
      else if (tick_hit && tgt_s != ramp_s)
        ramp_reg <= rising ? ramp_reg + 16'd1 : ramp_reg - 16'd1; // RL15
      // Set wins over a clear in the same cycle
      if (|vdi_flt)
        fault_reg <= 1'b1; // RL19
      else if (w_fclr)
        fault_reg <= 1'b0;
      rdata_reg <= rd_in ? rd_mux : 16'h0000;
    end
  end

  wire signed [15:0] out_trq = torque_mode ? ramp_s : 16'sh0000;
  assign torque_mode_out   = torque_mode;
  assign target_torque_out = ramp_reg;
  assign run_fwd_out       = torque_mode && !fault_reg && out_trq > 0; // RL6
  assign run_rev_out       = torque_mode && !fault_reg && out_trq < 0; // RL6
  assign freq_limit_out    = out_trq < 0 ? rev_lim_reg : fwd_lim_reg; // RL14
  assign vdi_state_out     = vdi_state;
  assign stop_out          = fault_reg; // RL19
  assign fault_code_out    = fault_reg ? USER_FAULT_ONE_CODE : 8'h00;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (addr_in)
      OFS_MODE:      rd_mux = {15'h0000, mode_reg};
      OFS_TSRC:      rd_mux = {13'h0000, tsrc_reg};
      OFS_TDIG:      rd_mux = tdig_reg;
      OFS_FWD_LIM:   rd_mux = fwd_lim_reg;
      OFS_REV_LIM:   rd_mux = rev_lim_reg;
      OFS_ACC:       rd_mux = acc_reg;
      OFS_DEC:       rd_mux = dec_reg;
      OFS_VDI_MODE:  rd_mux = {11'h000, vdi_mode_reg};
      OFS_VDI_FORCE: rd_mux = {11'h000, vdi_force_reg};
      OFS_COMM_TRQ:  rd_mux = comm_reg;
      OFS_STATUS:    rd_mux = {10'h000, fault_reg, vdi_state};
      OFS_TARGET:    rd_mux = ramp_reg;
      default:       rd_mux = (addr_in >= OFS_VDI_FN0
                               && addr_in < OFS_VDI_MODE)
                      ? {10'h000, vdi_fn_reg[3'(addr_in - OFS_VDI_FN0)]}
                      : 16'h0000;
    endcase
  end
  assign rdata_out = rdata_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_inhibit;
    @(posedge clk_in) disable iff (!nrst_in)
    inh_act |-> !torque_mode_out;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibit lost"); // RL3

  property p_swap;
    @(posedge clk_in) disable iff (!nrst_in)
    !inh_act |-> torque_mode_out == (mode_reg ^ swap_act);
  endproperty
  a_swap: assert property (p_swap) else $error("mode wrong"); // RL2

  property p_fault;
    @(posedge clk_in) disable iff (!nrst_in)
    (|vdi_flt) |=> stop_out && fault_code_out == USER_FAULT_ONE_CODE;
  endproperty
  a_fault: assert property (p_fault) else $error("fault missed"); // RL19

  property p_dir;
    @(posedge clk_in) disable iff (!nrst_in)
    !(run_fwd_out && run_rev_out);
  endproperty
  a_dir: assert property (p_dir) else $error("both directions"); // RL6

  property p_noramp;
    @(posedge clk_in) disable iff (!nrst_in)
    (nrst_in && no_ramp && $stable(tgt)) |=> target_torque_out == $past(tgt);
  endproperty
  a_noramp: assert property (p_noramp) else $error("ramp slow"); // RL15

  property p_digital;
    @(posedge clk_in) disable iff (!nrst_in)
    (nrst_in && tsrc_reg == TSRC_DIGITAL && no_ramp)
      |=> target_torque_out == $past(tdig_reg);
  endproperty
  a_digital: assert property (p_digital) else $error("dig src"); // RL7

  property p_vdi;
    @(posedge clk_in) disable iff (!nrst_in)
    vdi_state_out == ((vdi_mode_reg & vdi_force_reg)
      | (~vdi_mode_reg & vdo_eff));
  endproperty
  a_vdi: assert property (p_vdi) else $error("vdi source"); // RL17

  property p_rdata;
    @(posedge clk_in) disable iff (!nrst_in)
    (rd_in && addr_in == OFS_TDIG) |=> rdata_out == $past(tdig_reg);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data"); // RL5

  c_torque: cover property (@(posedge clk_in) torque_mode_out);
  c_fault:  cover property (@(posedge clk_in) stop_out);
  c_rev:    cover property (@(posedge clk_in) run_rev_out);

endmodule : tvs_top

// ==== tb/tvs_host_model.sv ====
`timescale 1ns/1ps
module tvs_host_model
  import tvs_pkg::*;
(
  // Clock and read data
  input  wire logic        clk_in,
  input  wire logic [15:0] rdata_in,
  // Register port master
  output logic      [7:0]  addr_out,
  output logic      [15:0] wdata_out,
  output logic             wr_out,
  output logic             rd_out,
  // Active protocol
  output logic      [1:0]  comm_sel_out
);
  // ----------------
  // Idle state
  // ----------------
  initial
  begin
    addr_out     = 8'h00;
    wdata_out    = 16'h0000;
    wr_out       = 1'h0;
    rd_out       = 1'h0;
    comm_sel_out = COMM_HOST;
  end

  // ----------------
  // Bus cycles
  // ----------------
  // One protocol owns the link at any time
  task automatic use_comm(input logic [1:0] c);
    @(posedge clk_in);
    comm_sel_out <= c;
  endtask : use_comm

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'h1;
    @(posedge clk_in);
    wr_out    <= 1'h0;
    // Released lines flip so a stale value never looks valid
    addr_out  <= ~a;
    wdata_out <= ~d;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'h1;
    @(posedge clk_in);
    rd_out   <= 1'h0;
    addr_out <= ~a;
    #1;
    d = rdata_in;
  endtask : rd_reg
endmodule : tvs_host_model

// ==== tb/torque_mode_and_virtual_input_select_test.sv ====
`timescale 1ns/1ps
module torque_mode_and_virtual_input_select_test
  import tvs_pkg::*;
;
  // ----------------
  // Signals
  // ----------------
  typedef struct packed {
    logic [2:0]  src;
    logic [1:0]  comm;
    logic        fb, mreg, sw, inh, tm;
    logic [15:0] trq;
  } tvs_row_s;

  logic        clk_in         = 1'h0;
  logic        nrst_in        = 1'h0;
  logic [7:0]  addr_in;
  logic [15:0] wdata_in, rdata_out, target_torque_out, freq_limit_out;
  logic        wr_in, rd_in;
  logic        di_swap_in     = 1'h0;
  logic        di_inhibit_in  = 1'h0;
  logic [4:0]  phys_di_in     = 5'h00;
  logic [4:0]  vdo_state_in   = 5'h00;
  logic [4:0]  vdo_fn_zero_in = 5'h00;
  logic [1:0]  comm_sel_in;
  logic        fbus_trq_in    = 1'h0;
  tvs_src_s    src_in         = '{16'h1388, 16'hF448, 16'h2710,
                                  16'h09C4, 16'h0123, 16'h0077};
  logic        torque_mode_out, run_fwd_out, run_rev_out, stop_out;
  logic [4:0]  vdi_state_out;
  logic [7:0]  fault_code_out;
  int          n_mismatch     = 0;
  int          n_tests        = 0;
  int          k;

  // Setpoint 100.0 %, so every scaled source reads as value / 10
  localparam tvs_row_s ROWS [17] = '{
    '{3'h0, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 16'h0000},
    '{3'h0, 2'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 16'h03E8},
    '{3'h0, 2'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 16'h03E8},
    '{3'h0, 2'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 16'h0000},
    '{3'h0, 2'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 16'h0000},
    '{3'h0, 2'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 16'h0000},
    '{3'h1, 2'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 16'h01F4},
    '{3'h2, 2'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 16'hFED4},
    '{3'h3, 2'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 16'h03E8},
    '{3'h4, 2'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 16'h00FA},
    '{3'h5, 2'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 16'hFC18},
    '{3'h5, 2'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 16'h0123},
    '{3'h5, 2'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 16'hFC18},
    '{3'h5, 2'h2, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 16'h0077},
    '{3'h5, 2'h3, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 16'hFC18},
    '{3'h6, 2'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 16'hFED4},
    '{3'h7, 2'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 16'h01F4}};
  localparam logic [7:0]  RA [13] = '{OFS_MODE, OFS_TSRC, OFS_TDIG,
    OFS_FWD_LIM, OFS_REV_LIM, OFS_ACC, OFS_DEC, OFS_VDI_FN0, 8'h0C,
    OFS_VDI_MODE, OFS_VDI_FORCE, 8'h07, 8'hFF};
  localparam logic [15:0] RE [13] = '{16'h0000, 16'h0000, 16'h05DC,
    16'h1388, 16'h1388, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [7:0]  WA [6] = '{OFS_TDIG, OFS_TDIG, OFS_TDIG,
    OFS_VDI_FN0, OFS_VDI_FN0, OFS_VDI_FN0};
  localparam logic [15:0] WD [6] = '{16'h07D1, 16'h07D0, 16'hF830,
    16'h003C, 16'h003B, 16'h0000};
  localparam logic [15:0] WE [6] = '{16'h05DC, 16'h07D0, 16'hF830,
    16'h0000, 16'h003B, 16'h0000};

  always #2.5 clk_in = ~clk_in;

  // ----------------
  // Instances
  // ----------------
  // Short ramp tick keeps the run brief
  tvs_top #(.TICK(4)) DUT (.clk_in(clk_in), .nrst_in(nrst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .di_swap_in(di_swap_in),
    .di_inhibit_in(di_inhibit_in), .phys_di_in(phys_di_in),
    .vdo_state_in(vdo_state_in), .vdo_fn_zero_in(vdo_fn_zero_in),
    .comm_sel_in(comm_sel_in), .fbus_trq_in(fbus_trq_in), .src_in(src_in),
    .torque_mode_out(torque_mode_out), .target_torque_out(target_torque_out),
    .freq_limit_out(freq_limit_out), .vdi_state_out(vdi_state_out),
    .run_fwd_out(run_fwd_out), .run_rev_out(run_rev_out),
    .stop_out(stop_out), .fault_code_out(fault_code_out));

  tvs_host_model host (.clk_in(clk_in), .rdata_in(rdata_out),
    .addr_out(addr_in), .wdata_out(wdata_in), .wr_out(wr_in),
    .rd_out(rd_in), .comm_sel_out(comm_sel_in));

  // ----------------
  // Checking
  // ----------------
  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic rd_check(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] v;
    host.rd_reg(a, v);
    check("register read", v, e);
  endtask : rd_check

  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : settle

  task automatic report_and_stop();
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // ----------------
  // Sequence
  // ----------------
  initial
  begin
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'h1;
    host.wr_reg(OFS_TDIG, 16'h03E8);
    host.wr_reg(OFS_FWD_LIM, 16'h1000);
    host.wr_reg(OFS_REV_LIM, 16'h0800);
    host.wr_reg(OFS_COMM_TRQ, 16'hD8F0);
    foreach (ROWS[i])
    begin
      host.wr_reg(OFS_MODE, {15'h0000, ROWS[i].mreg});
      host.wr_reg(OFS_TSRC, {13'h0000, ROWS[i].src});
      host.use_comm(ROWS[i].comm);
      @(posedge clk_in);
      fbus_trq_in   <= ROWS[i].fb;
      di_swap_in    <= ROWS[i].sw;
      di_inhibit_in <= ROWS[i].inh;
      settle(3);
      check("torque_mode", torque_mode_out, ROWS[i].tm);
      if (ROWS[i].tm)
      begin
        check("target", target_torque_out,
              ROWS[i].trq);
        check("run_fwd", run_fwd_out, !ROWS[i].trq[15]);
        check("run_rev", run_rev_out, ROWS[i].trq[15]);
        check("freq_limit", freq_limit_out,
              ROWS[i].trq[15] ? 16'h0800 : 16'h1000);
      end
    end
    // Second reset in mid-run
    @(posedge clk_in);
    nrst_in <= 1'h0;
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'h1;
    #1;
    check("torque_mode", torque_mode_out, 1'h0);
    for (k = 0; k < 13; k++)
      rd_check(RA[k], RE[k]);
    for (k = 0; k < 6; k++)
    begin
      host.wr_reg(WA[k], WD[k]);
      rd_check(WA[k], WE[k]);
    end
    @(posedge clk_in);
    phys_di_in     <= 5'h15;
    vdo_state_in   <= 5'h0C;
    vdo_fn_zero_in <= 5'h03;
    host.wr_reg(OFS_VDI_MODE, 16'h0012);
    host.wr_reg(OFS_VDI_FORCE, 16'h0010);
    settle(1);
    check("vdi_state", vdi_state_out, 5'h1D);
    rd_check(OFS_STATUS, 16'h001D);
    host.wr_reg(OFS_VDI_MODE, 16'h0001);
    host.wr_reg(OFS_VDI_FORCE, 16'h0001);
    host.wr_reg(OFS_VDI_FN0, 16'h002C);
    settle(2);
    check("stop", stop_out, 1'h1);
    check("fault_code", fault_code_out, 8'h1B);
    rd_check(OFS_STATUS, 16'h002D);
    host.wr_reg(OFS_VDI_FORCE, 16'h0000);
    host.wr_reg(OFS_VDI_FN0, 16'h0000);
    settle(1);
    check("stop", stop_out, 1'h1);
    host.wr_reg(OFS_FAULT_CLR, 16'h0001);
    settle(1);
    check("stop", stop_out, 1'h0);
    check("fault_code", fault_code_out, 8'h00);
    host.wr_reg(OFS_VDI_FN0 + 8'h01, 16'h002E);
    host.wr_reg(OFS_VDI_MODE, 16'h0002);
    host.wr_reg(OFS_VDI_FORCE, 16'h0002);
    settle(1);
    check("torque_mode", torque_mode_out, 1'h1);
    host.wr_reg(OFS_VDI_FN0 + 8'h02, 16'h001D);
    host.wr_reg(OFS_VDI_MODE, 16'h0006);
    host.wr_reg(OFS_VDI_FORCE, 16'h0006);
    settle(1);
    check("torque_mode", torque_mode_out, 1'h0);
    host.wr_reg(OFS_VDI_FN0 + 8'h01, 16'h0000);
    host.wr_reg(OFS_VDI_FN0 + 8'h02, 16'h0000);
    host.wr_reg(OFS_MODE, 16'h0001);
    host.wr_reg(OFS_TDIG, 16'h03E8);
    host.wr_reg(OFS_ACC, 16'h0064);
    host.wr_reg(OFS_DEC, 16'h0064);
    host.wr_reg(OFS_TDIG, 16'h03F2);
    settle(4);
    check("ramp_busy", target_torque_out == 16'h03F2, 1'h0);
    for (k = 0; k < 200 && target_torque_out !== 16'h03F2; k++)
    begin
      @(posedge clk_in);
      #1;
    end
    // A ramp that never arrives counts as a mismatch
    if (k == 200)
      n_mismatch++;
    check("ramp_rate", k >= 24, 1'h1);
    rd_check(OFS_TARGET, 16'h03F2);
    report_and_stop();
  end
endmodule : torque_mode_and_virtual_input_select_test
